// ===== ldo_setpoint_control_register.sv
`timescale 1ns/100ps
module ldo_setpoint_control_register
  import ldo_setpoint_pkg::*;
(
  // Clock and asynchronous reset
  input  wire logic                           clk_in,
  input  wire logic                           reset_in,
  // Register access
  input  wire logic [7:0]                     addr_in,
  input  wire logic                           wr_en_in,
  input  wire logic [7:0]                     wr_data_in,
  input  wire logic                           unlocked_in,
  // Third buck converter setting, followed while tracking
  input  wire logic [ldo_setpoint_pkg::CODE_W-1:0] buck_code_in,
  // Read data and regulator controls
  output logic      [7:0]                     rd_data_out,
  output logic                                track_out,
  output logic      [ldo_setpoint_pkg::CODE_W-1:0] setpoint_code_out
);
  import ldo_setpoint_pkg::*;

  // Value shown after reset and for any other address
  localparam logic [7:0]        READ_IDLE  = 8'h00;
  // Writable bits of the code field alone
  localparam logic [CODE_W-1:0] CODE_MASK  = WRITABLE_MASK[CODE_MSB:0];
  // Reset value of the tracking field
  localparam logic              TRACK_INIT = REG_RESET[TRACK_BIT];
  // Reset value of the code field
  localparam logic [CODE_W-1:0] CODE_INIT  = REG_RESET[CODE_MSB:0];

  // Address decode of this register
  logic              hit;
  // Strobe, address and unlock seen together
  logic              wr_take;
  // Tracking bit carried by the write data
  logic              wr_track;
  // Code carried by the write data
  logic [CODE_W-1:0] wr_code;

  // Stored tracking field
  logic              track_r;
  // Tracking field after an accepted write
  logic              track_nxt;
  // Stored code; its LSB never leaves the reset value
  logic [CODE_W-1:0] code_r;
  // Code after an accepted write
  logic [CODE_W-1:0] code_nxt;

  // Byte as software reads it
  logic [7:0]        view;
  // Read data before its output flop
  logic [7:0]        rd_nxt;
  // Tracking flag before its output flop
  logic              track_out_nxt;

  // True when the bus address selects this register
  function automatic logic addr_match
  (
    input logic [7:0] a
  );
  begin
    addr_match = (a == REG_ADDR);
  end
  endfunction

  // Old value keeps protected bits, write supplies the rest
  function automatic logic [CODE_W-1:0] merge_code
  (
    input logic [CODE_W-1:0] old_v,
    input logic [CODE_W-1:0] new_v
  );
  begin
    merge_code = (old_v & ~CODE_MASK) | (new_v & CODE_MASK);
  end
  endfunction

  // Readable byte from the fields; reserved bit hard wired low
  function automatic logic [7:0] pack_view
  (
    input logic              trk,
    input logic [CODE_W-1:0] code
  );
  begin
    pack_view = {1'b0, trk, code}; // [R03]
  end
  endfunction

  // Selected byte, or the idle value for any other address
  function automatic logic [7:0] read_mux
  (
    input logic       sel,
    input logic [7:0] v
  );
  begin
    read_mux = sel ? v : READ_IDLE;
  end
  endfunction

  // Address decode shared by the write gate and the read select
  assign hit = addr_match(addr_in); // [R01]

  // Field slices of the write data; bit 7 is never looked at
  assign wr_track = wr_data_in[TRACK_BIT]; // [R03] [R07]
  assign wr_code  = wr_data_in[CODE_MSB:0];

  // Write gate; locked or misaddressed writes vanish without a trace
  always_comb
  begin
    wr_take = 1'b0;
    if (wr_en_in)
    begin
      if (hit && unlocked_in)
      begin
        wr_take = 1'b1; // [R02]
      end
    end
  end

  // Next tracking field
  always_comb
  begin
    track_nxt = track_r;
    if (wr_take)
    begin
      track_nxt = wr_track; // [R04]
    end
  end

  // Next code; the LSB is masked so it stays at its reset value
  always_comb
  begin
    code_nxt = code_r;
    if (wr_take)
    begin
      code_nxt = merge_code(code_r, wr_code); // [R05] [R06]
    end
  end

  // Tracking field storage
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      track_r <= TRACK_INIT; // [R01] [R04]
    end
    else
    begin
      track_r <= track_nxt;
    end
  end

  // Code field storage
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      code_r <= CODE_INIT; // [R01] [R05]
    end
    else
    begin
      code_r <= code_nxt; // [R06]
    end
  end

  // Readable byte rebuilt from the fields every cycle
  always_comb
  begin
    view = pack_view(track_r, code_r); // [R07]
  end

  // Read select; no read strobe, so polling any address is harmless
  always_comb
  begin
    rd_nxt = read_mux(hit, view); // [R01]
  end

  // Read port registered; shows the byte stored before this edge
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      rd_data_out <= READ_IDLE;
    end
    else
    begin
      rd_data_out <= rd_nxt; // [R03] [R07]
    end
  end

  // Tracking flag follows storage, in step with the code path
  always_comb
  begin
    track_out_nxt = track_r; // [R04]
  end

  // Tracking flag out, one cycle behind storage like the code
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      track_out <= TRACK_INIT; // [R04]
    end
    else
    begin
      track_out <= track_out_nxt;
    end
  end

  // Effective code: own field or third buck code, clamped and registered
  ldo_setpoint_select u_select (
    // Clock and reset
    .clk_in       (clk_in),
    .reset_in     (reset_in),
    // Stored fields
    .track_in     (track_r),
    .own_code_in  (code_r),
    // Third buck setting
    .buck_code_in (buck_code_in),
    // Registered, clamped code straight to the output
    .code_out     (setpoint_code_out)
  );

endmodule // ldo_setpoint_control_register

// ===== ldo_setpoint_pkg.sv
// Function
// R01 - Register sits at address 0x13 and resets to 0x38.
// R02 - Writes take effect only while the password unlock is satisfied.
// R03 - Bit 7 is reserved, read-only, always reads 0.
// R04 - Tracking bit 6 makes setpoint follow third buck setting; resets to 0.
// R05 - Clear tracking uses six-bit code; 0 is 0.9 V, 0x38 up is 3.3 V.
// R06 - Setpoint code LSB is not programmable; writes to it are ignored.
// R07 - Reserved-bit writes ignored; reads return stored tracking bit and code.
package ldo_setpoint_pkg;
  localparam logic [7:0] REG_ADDR        = 8'h13;
  localparam logic [7:0] REG_RESET       = 8'h38;
  localparam int         TRACK_BIT       = 6;
  localparam int         CODE_MSB        = 5;
  localparam int         CODE_W          = 6;
  localparam logic [5:0] CODE_MAX        = 6'h38;
  localparam logic [7:0] WRITABLE_MASK   = 8'h7E;
endpackage

// ===== ldo_setpoint_select.sv
`timescale 1ns/100ps
// Chooses the effective regulator code and clamps it
module ldo_setpoint_select
  import ldo_setpoint_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              reset_in,
  input  wire logic              track_in,
  input  wire logic [CODE_W-1:0] own_code_in,
  input  wire logic [CODE_W-1:0] buck_code_in,
  output logic      [CODE_W-1:0] code_out
);
  // Codes above the top step all mean 3.3 V, so clamp once here
  function automatic logic [CODE_W-1:0] clamp_code(input logic [CODE_W-1:0] c);
    clamp_code = (c > CODE_MAX) ? CODE_MAX : c;
  endfunction

  // Registered output keeps the regulator input glitch free
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      code_out <= REG_RESET[CODE_MSB:0];
    else if (track_in)
      code_out <= clamp_code(buck_code_in); // [R04]
    else
      code_out <= clamp_code(own_code_in); // [R05]
  end
endmodule // ldo_setpoint_select

// ===== ldo_setpoint_sva.sv
`timescale 1ns/100ps
module setpoint_chk
  import ldo_setpoint_pkg::*;
(
  input wire logic clk_in, reset_in, wr_en_in, unlocked_in, track_out,
  input wire logic [7:0] addr_in, wr_data_in, rd_data_out,
  input wire logic [5:0] buck_code_in, setpoint_code_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  chk_fixed_bits: assert property (rd_data_out[7]==0 && rd_data_out[0]==0)
    else $error("fixed bit set");
  chk_code_clamp: assert property (setpoint_code_out <= CODE_MAX)
    else $error("code above max");
  chk_locked_hold: assert property ((!(wr_en_in&&unlocked_in))[*2] |=> $stable(track_out))
    else $error("track changed");
  chk_track_follow: assert property (track_out |-> setpoint_code_out ==
    ($past(buck_code_in) > CODE_MAX ? CODE_MAX : $past(buck_code_in))) else $error("no follow");
  chk_read_track: assert property ($past(addr_in)==REG_ADDR |-> rd_data_out[6]==track_out)
    else $error("read track");
  chk_unmapped_zero: assert property ($past(addr_in)!=REG_ADDR |-> rd_data_out==0)
    else $error("unmapped read");
  chk_reset_value: assert property ($fell(reset_in) |-> !track_out && setpoint_code_out==6'h38)
    else $error("reset value");
  chk_own_code: assert property (!$past(reset_in) && $past(addr_in)==REG_ADDR
    && !rd_data_out[6] |-> setpoint_code_out ==
    (rd_data_out[5:0] > CODE_MAX ? CODE_MAX : rd_data_out[5:0])) else $error("own code");
endmodule // setpoint_chk
bind ldo_setpoint_control_register setpoint_chk chk_i (.*);

// ===== tb.sv
`timescale 1ns/100ps
module tb;
  logic clk_in=0, reset_in=1, wr_en_in=0, unlocked_in=0, track_out;
  logic [7:0] addr_in=8'h13, wr_data_in=8'h00, rd_data_out;
  logic [5:0] buck_code_in=6'h3F, setpoint_code_out;
  int num_errors=0, compares=0;
  ldo_setpoint_control_register uut (.*);
  always #50 clk_in = ~clk_in;
  task chk(logic [7:0] s, e); compares++; if (s !== e) begin num_errors++;
    $display("wrong value %0t seen %h", $time, s); end endtask
  // One write, then two edges so read data and outputs settle
  task wr(logic [7:0] d, logic u); @(posedge clk_in); #5 wr_en_in=1; wr_data_in=d; unlocked_in=u;
    @(posedge clk_in); #5 wr_en_in=0; @(posedge clk_in); @(posedge clk_in); #5; endtask
  task give_verdict; $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors==0 && compares>0) $display("DONE - PASS"); else $display("DONE - FAIL");
    $finish; endtask
  // Watchdog, far beyond the few dozen cycles of the tests
  initial begin #20000 num_errors++; give_verdict; end
  initial begin
    #405 reset_in=0; #100 chk(rd_data_out, 8'h38);
    chk(setpoint_code_out, 6'h38);
    chk(track_out, 1'b0);
    wr(8'hFF,0); chk(rd_data_out, 8'h38);
    buck_code_in=6'h15; wr(8'hFF,1); chk(rd_data_out, 8'h7E);
    chk(setpoint_code_out, 6'h15);
    chk(track_out, 1'b1);
    wr(8'h3F,1); chk(rd_data_out, 8'h3E);
    chk(setpoint_code_out, 6'h38);
    chk(track_out, 1'b0);
    wr(8'h81,1); chk(setpoint_code_out, 6'h00);
    addr_in=8'h14; wr(8'h7E,1); chk(rd_data_out, 8'h00);
    addr_in=8'h13; wr(8'h7E,0); chk(rd_data_out, 8'h00);
    give_verdict;
  end
endmodule // tb
